// >>> core/ropm_matrix.sv
// Remappable output pin select matrix, top level
`timescale 1ns/1ps
module ropm_matrix
  import ropm_pkg::*;
#(
  parameter bit HAS_CAN   = 1'b1,
  parameter bit HAS_MOTOR = 1'b1
) (
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                wr_en,
  input  wire logic [2:0]          wr_pin,
  input  wire logic [SEL_W-1:0]    wr_code,
  input  wire logic                serial_port_a_transmit,
  input  wire logic                serial_port_b_transmit,
  input  wire logic                spi_b_data_out,
  input  wire logic                spi_b_clock_out,
  input  wire logic                spi_b_slave_select,
  input  wire logic                can_transmit,
  input  wire logic                compare_out_one,
  input  wire logic                compare_out_two,
  input  wire logic                compare_out_three,
  input  wire logic                compare_out_four,
  input  wire logic                comparator_one_out,
  input  wire logic                comparator_two_out,
  input  wire logic                comparator_three_out,
  input  wire logic                comparator_four_out,
  input  wire logic                pwm_timebase_sync_out,
  input  wire logic                encoder_counter_compare_out,
  input  wire logic                reference_clock_out,
  output logic [NUM_PINS-1:0]      remappable_pin,
  output logic [NUM_PINS-1:0]      pin_peripheral_owned
);
  // =============================================================
  // Select code store
  ropm_sel_if sel_bus ();

  ropm_sel_store u_store (
    .clock   (clock),
    .rstn    (rstn),
    .wr_en   (wr_en),
    .wr_pin  (wr_pin),
    .wr_code (wr_code),
    .sel_bus (sel_bus)
  );

  // =============================================================
  // Source vector gathering
  ropm_src_t src;

  always_comb begin
    src                = '0;
    src[SRC_UART_A_TX] = serial_port_a_transmit;
    src[SRC_UART_B_TX] = serial_port_b_transmit;
    src[SRC_SPI_B_DO]  = spi_b_data_out;
    src[SRC_SPI_B_CK]  = spi_b_clock_out;
    src[SRC_SPI_B_SS]  = spi_b_slave_select;
    src[SRC_CAN_TX]    = can_transmit;
    src[SRC_CMP_OUT1]  = compare_out_one;
    src[SRC_CMP_OUT2]  = compare_out_two;
    src[SRC_CMP_OUT3]  = compare_out_three;
    src[SRC_CMP_OUT4]  = compare_out_four;
    src[SRC_COMP1]     = comparator_one_out;
    src[SRC_COMP2]     = comparator_two_out;
    src[SRC_COMP3]     = comparator_three_out;
    src[SRC_COMP4]     = comparator_four_out;
    src[SRC_PWM_SYNC]  = pwm_timebase_sync_out;
    src[SRC_QEI_CMP]   = encoder_counter_compare_out;
    src[SRC_REFCLK]    = reference_clock_out;
  end

  // =============================================================
  // Code decode: returns {owned, level}; shared by every pin
  function automatic logic [1:0] ropm_route(input ropm_sel_t code, input ropm_src_t s);
    logic [1:0] r;
    r = 2'h0;
    case (code)
      SEL_UART_A_TX: r = {1'b1, s[SRC_UART_A_TX]};
      SEL_UART_B_TX: r = {1'b1, s[SRC_UART_B_TX]};
      SEL_SPI_B_DO:  r = {1'b1, s[SRC_SPI_B_DO]};
      SEL_SPI_B_CK:  r = {1'b1, s[SRC_SPI_B_CK]};
      SEL_SPI_B_SS:  r = {1'b1, s[SRC_SPI_B_SS]};
      SEL_CAN_TX:    r = HAS_CAN ? {1'b1, s[SRC_CAN_TX]} : 2'h0;
      SEL_CMP_OUT1:  r = {1'b1, s[SRC_CMP_OUT1]};
      SEL_CMP_OUT2:  r = {1'b1, s[SRC_CMP_OUT2]};
      SEL_CMP_OUT3:  r = {1'b1, s[SRC_CMP_OUT3]};
      SEL_CMP_OUT4:  r = {1'b1, s[SRC_CMP_OUT4]};
      SEL_COMP1:     r = {1'b1, s[SRC_COMP1]};
      SEL_COMP2:     r = {1'b1, s[SRC_COMP2]};
      SEL_COMP3:     r = {1'b1, s[SRC_COMP3]};
      SEL_COMP4:     r = {1'b1, s[SRC_COMP4]};
      SEL_PWM_SYNC:  r = HAS_MOTOR ? {1'b1, s[SRC_PWM_SYNC]} : 2'h0;
      SEL_QEI_CMP:   r = HAS_MOTOR ? {1'b1, s[SRC_QEI_CMP]} : 2'h0;
      SEL_REFCLK:    r = {1'b1, s[SRC_REFCLK]};
      default:       r = 2'h0;
    endcase
    return r;
  endfunction : ropm_route

  // =============================================================
  // Registered pin outputs; one cycle of latency traded for clean outputs
  logic [NUM_PINS-1:0] next_pin;
  logic [NUM_PINS-1:0] next_owned;

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      {next_owned[i], next_pin[i]} = ropm_route(sel_bus.sel[i], src);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      remappable_pin       <= '0;
      pin_peripheral_owned <= '0;
    end else begin
      remappable_pin       <= next_pin;
      pin_peripheral_owned <= next_owned;
    end
  end

  // =============================================================
  // Checks
  property p_reset_default;
    @(posedge clock) $rose(rstn) |-> (pin_peripheral_owned == '0) && (remappable_pin == '0);
  endproperty
  a_reset_default: assert property (p_reset_default) else $error("pin owned right after reset");

  property p_refclk_route;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[0] == SEL_REFCLK) |=> (remappable_pin[0] == $past(reference_clock_out)
                                          && pin_peripheral_owned[0]);
  endproperty
  a_refclk_route: assert property (p_refclk_route) else $error("refclk not routed to pin 0");

  property p_uart_a_route;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[0] == SEL_UART_A_TX) |=> (remappable_pin[0] == $past(serial_port_a_transmit));
  endproperty
  a_uart_a_route: assert property (p_uart_a_route) else $error("serial A not routed to pin 0");

  property p_spi_clk_route;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[3] == SEL_SPI_B_CK) |=> (remappable_pin[3] == $past(spi_b_clock_out));
  endproperty
  a_spi_clk_route: assert property (p_spi_clk_route) else $error("spi clock not routed to pin 3");

  property p_cmp4_route;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[1] == SEL_CMP_OUT4) |=> (remappable_pin[1] == $past(compare_out_four));
  endproperty
  a_cmp4_route: assert property (p_cmp4_route) else $error("compare four not routed to pin 1");

  property p_comp4_route;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[5] == SEL_COMP4) |=> (remappable_pin[5] == $past(comparator_four_out));
  endproperty
  a_comp4_route: assert property (p_comp4_route) else $error("comparator four not routed to pin 5");

  property p_unassigned_idle;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[3] == 6'h02 || sel_bus.sel[3] == 6'h3f) |=> !pin_peripheral_owned[3] && !remappable_pin[3];
  endproperty
  a_unassigned_idle: assert property (p_unassigned_idle) else $error("unassigned code drove pin 3");

  property p_shared_source;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[6] == sel_bus.sel[7]) |=> (remappable_pin[6] == remappable_pin[7]);
  endproperty
  a_shared_source: assert property (p_shared_source) else $error("pins 6 and 7 disagree on same code");

  property p_write_takes;
    @(posedge clock) disable iff (!rstn)
      wr_en ##1 1'b1 |-> (sel_bus.sel[$past(wr_pin)] == $past(wr_code));
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("select code write lost");

  // =============================================================
  // Further routes, one pin each; pins chosen where codes really land
  property p_uart_b_route;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[1] == SEL_UART_B_TX) |=> (remappable_pin[1] == $past(serial_port_b_transmit));
  endproperty
  a_uart_b_route: assert property (p_uart_b_route) else $error("serial B not routed to pin 1");

  property p_spi_ss_route;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[4] == SEL_SPI_B_SS) |=> (remappable_pin[4] == $past(spi_b_slave_select));
  endproperty
  a_spi_ss_route: assert property (p_spi_ss_route) else $error("spi select not routed to pin 4");

  // Absent variant must look exactly like code zero, owned flag included
  property p_can_route;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[5] == SEL_CAN_TX) |=> (pin_peripheral_owned[5] == HAS_CAN)
                                         && (remappable_pin[5] == (HAS_CAN && $past(can_transmit)));
  endproperty
  a_can_route: assert property (p_can_route) else $error("can transmit wrong on pin 5");

  property p_cmp1_route;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[6] == SEL_CMP_OUT1) |=> (remappable_pin[6] == $past(compare_out_one));
  endproperty
  a_cmp1_route: assert property (p_cmp1_route) else $error("compare one not routed to pin 6");

  property p_comp1_route;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[2] == SEL_COMP1) |=> (remappable_pin[2] == $past(comparator_one_out));
  endproperty
  a_comp1_route: assert property (p_comp1_route) else $error("comparator one not routed to pin 2");

  property p_pwm_sync_route;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[6] == SEL_PWM_SYNC)
        |=> (remappable_pin[6] == (HAS_MOTOR && $past(pwm_timebase_sync_out)));
  endproperty
  a_pwm_sync_route: assert property (p_pwm_sync_route) else $error("pwm sync wrong on pin 6");

  property p_encoder_route;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[7] == SEL_QEI_CMP)
        |=> (remappable_pin[7] == (HAS_MOTOR && $past(encoder_counter_compare_out)));
  endproperty
  a_encoder_route: assert property (p_encoder_route) else $error("encoder compare wrong on pin 7");

  property p_default_code;
    @(posedge clock) disable iff (!rstn)
      (sel_bus.sel[7] == SEL_DEFAULT) |=> !pin_peripheral_owned[7] && !remappable_pin[7];
  endproperty
  a_default_code: assert property (p_default_code) else $error("pin 7 driven under code zero");

  // Whole path from write to pin: store edge, then register edge
  sequence s_refclk_write;
    wr_en && (wr_pin == 3'h0) && (wr_code == SEL_REFCLK);
  endsequence

  sequence s_pin0_follows_refclk;
    pin_peripheral_owned[0] && (remappable_pin[0] == $past(reference_clock_out));
  endsequence

  property p_write_then_route;
    @(posedge clock) disable iff (!rstn)
      s_refclk_write |-> ##2 s_pin0_follows_refclk;
  endproperty
  a_write_then_route: assert property (p_write_then_route) else $error("pin 0 late after code write");
endmodule : ropm_matrix

// >>> core/ropm_pkg.sv
// Constants and types for the remappable output pin select matrix
// =============================================================
// How it works
// - Every remappable pin owns a six-bit select code choosing its peripheral source.
// - Select codes reset to zero; zero means pin keeps its default port function.
// - No interlocks: any code combination across pins is accepted, sharing allowed.
// - Code 01 routes serial port A transmit; code 03 routes serial port B transmit.
// - Codes 08, 09, 0a route SPI B data, clock and slave select outputs.
// - Code 0e routes CAN transmit, only when the variant includes CAN.
// - Codes 10 to 13 route compare outputs one to four in order.
// - Codes 18, 19, 1a route comparators one to three; code 32 routes comparator four.
// - Code 2d routes PWM sync, code 2f encoder compare; motor variants only.
// - Code 31 routes the reference clock output to the pin.
package ropm_pkg;
  // =============================================================
  // Sizes
  localparam int unsigned NUM_PINS   = 8;
  localparam int unsigned SEL_W      = 6;
  localparam int unsigned NUM_SRC    = 18;
  localparam logic [SEL_W-1:0] SEL_RESET = 6'h00;

  // =============================================================
  // Select codes
  localparam logic [SEL_W-1:0] SEL_DEFAULT   = 6'h00;
  localparam logic [SEL_W-1:0] SEL_UART_A_TX = 6'h01;
  localparam logic [SEL_W-1:0] SEL_UART_B_TX = 6'h03;
  localparam logic [SEL_W-1:0] SEL_SPI_B_DO  = 6'h08;
  localparam logic [SEL_W-1:0] SEL_SPI_B_CK  = 6'h09;
  localparam logic [SEL_W-1:0] SEL_SPI_B_SS  = 6'h0a;
  localparam logic [SEL_W-1:0] SEL_CAN_TX    = 6'h0e;
  localparam logic [SEL_W-1:0] SEL_CMP_OUT1  = 6'h10;
  localparam logic [SEL_W-1:0] SEL_CMP_OUT2  = 6'h11;
  localparam logic [SEL_W-1:0] SEL_CMP_OUT3  = 6'h12;
  localparam logic [SEL_W-1:0] SEL_CMP_OUT4  = 6'h13;
  localparam logic [SEL_W-1:0] SEL_COMP1     = 6'h18;
  localparam logic [SEL_W-1:0] SEL_COMP2     = 6'h19;
  localparam logic [SEL_W-1:0] SEL_COMP3     = 6'h1a;
  localparam logic [SEL_W-1:0] SEL_PWM_SYNC  = 6'h2d;
  localparam logic [SEL_W-1:0] SEL_QEI_CMP   = 6'h2f;
  localparam logic [SEL_W-1:0] SEL_REFCLK    = 6'h31;
  localparam logic [SEL_W-1:0] SEL_COMP4     = 6'h32;

  // =============================================================
  // Source vector bit positions
  localparam int unsigned SRC_UART_A_TX = 0;
  localparam int unsigned SRC_UART_B_TX = 1;
  localparam int unsigned SRC_SPI_B_DO  = 2;
  localparam int unsigned SRC_SPI_B_CK  = 3;
  localparam int unsigned SRC_SPI_B_SS  = 4;
  localparam int unsigned SRC_CAN_TX    = 5;
  localparam int unsigned SRC_CMP_OUT1  = 6;
  localparam int unsigned SRC_CMP_OUT2  = 7;
  localparam int unsigned SRC_CMP_OUT3  = 8;
  localparam int unsigned SRC_CMP_OUT4  = 9;
  localparam int unsigned SRC_COMP1     = 10;
  localparam int unsigned SRC_COMP2     = 11;
  localparam int unsigned SRC_COMP3     = 12;
  localparam int unsigned SRC_COMP4     = 13;
  localparam int unsigned SRC_PWM_SYNC  = 14;
  localparam int unsigned SRC_QEI_CMP   = 15;
  localparam int unsigned SRC_REFCLK    = 16;
  localparam int unsigned SRC_SPARE     = 17;

  typedef logic [SEL_W-1:0] ropm_sel_t;
  typedef logic [NUM_SRC-1:0] ropm_src_t;
endpackage : ropm_pkg

// >>> core/ropm_sel_if.sv
// Interface carrying the select codes from the store to the matrix
`timescale 1ns/1ps
interface ropm_sel_if;
  import ropm_pkg::*;
  ropm_sel_t sel [NUM_PINS];

  modport store (output sel);
  modport matrix (input sel);
endinterface : ropm_sel_if

// >>> core/ropm_sel_store.sv
// Storage of the per-pin select codes
`timescale 1ns/1ps
module ropm_sel_store
  import ropm_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             wr_en,
  input  wire logic [2:0]       wr_pin,
  input  wire ropm_sel_t        wr_code,
  ropm_sel_if.store             sel_bus
);
  // =============================================================
  // Select code registers
  ropm_sel_t codes [NUM_PINS];

  // Each pin written on its own; no cross-pin checks
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        codes[i] <= SEL_RESET;
      end
    end else if (wr_en) begin
      codes[wr_pin] <= wr_code;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      sel_bus.sel[i] = codes[i];
    end
  end
endmodule : ropm_sel_store

// >>> tb/ropm_matrix_bench.sv
// Self-checking bench for the remappable output pin select matrix
`timescale 1ns/1ps
module ropm_matrix_bench;
  import ropm_pkg::*;
  logic                clock;
  logic                rstn;
  logic                wr_en;
  logic [2:0]          wr_pin;
  ropm_sel_t           wr_code;
  ropm_src_t           level_set;
  ropm_src_t           lines;
  logic [NUM_PINS-1:0] remappable_pin;
  logic [NUM_PINS-1:0] pin_peripheral_owned;
  int                  fail_count;
  int                  checks_done;
  ropm_sel_t           codes [17];
  int                  srcs [17];

  // =============================================================
  // Clock and instances
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ropm_periph_model ropm_periph_model_inst (.clock(clock), .rstn(rstn), .level_set(level_set), .lines(lines));

  ropm_matrix ropm_matrix_inst (
    .clock(clock), .rstn(rstn), .wr_en(wr_en), .wr_pin(wr_pin), .wr_code(wr_code),
    .serial_port_a_transmit(lines[SRC_UART_A_TX]), .serial_port_b_transmit(lines[SRC_UART_B_TX]),
    .spi_b_data_out(lines[SRC_SPI_B_DO]), .spi_b_clock_out(lines[SRC_SPI_B_CK]),
    .spi_b_slave_select(lines[SRC_SPI_B_SS]), .can_transmit(lines[SRC_CAN_TX]),
    .compare_out_one(lines[SRC_CMP_OUT1]), .compare_out_two(lines[SRC_CMP_OUT2]),
    .compare_out_three(lines[SRC_CMP_OUT3]), .compare_out_four(lines[SRC_CMP_OUT4]),
    .comparator_one_out(lines[SRC_COMP1]), .comparator_two_out(lines[SRC_COMP2]),
    .comparator_three_out(lines[SRC_COMP3]), .comparator_four_out(lines[SRC_COMP4]),
    .pwm_timebase_sync_out(lines[SRC_PWM_SYNC]), .encoder_counter_compare_out(lines[SRC_QEI_CMP]),
    .reference_clock_out(lines[SRC_REFCLK]), .remappable_pin(remappable_pin),
    .pin_peripheral_owned(pin_peripheral_owned));

  // =============================================================
  // Shared tasks
  task automatic check(input logic [NUM_PINS-1:0] got, input logic [NUM_PINS-1:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // One write per edge; caller may chain calls for back-to-back writes
  task automatic wr(input logic [2:0] pin, input ropm_sel_t code);
    wr_en = 1'b1;
    wr_pin = pin;
    wr_code = code;
    @(posedge clock);
    #1;
  endtask : wr

  // Three edges cover model launch plus the matrix's own register stage
  task automatic settle();
    wr_en = 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask : settle

  task automatic end_of_test();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // =============================================================
  // Scenarios
  task automatic sc_codes();
    logic [NUM_PINS-1:0] m;
    for (int i = 0; i < 17; i++) begin
      m = 8'h01 << (i % 8);
      level_set = '0;
      level_set[srcs[i]] = 1'b1;
      wr(3'(i % 8), codes[i]);
      settle();
      check(pin_peripheral_owned & m, m, "owned after code");
      check(remappable_pin & m, m, "selected source high");
      // Every other source high: a wrong pick shows as a high pin
      level_set = ~level_set;
      settle();
      check(remappable_pin & m, 8'h00, "selected source low");
    end
  endtask : sc_codes

  task automatic sc_unassigned();
    ropm_sel_t bad [4];
    bad = '{6'h02, 6'h0f, 6'h20, 6'h3f};
    level_set = '1;
    for (int i = 0; i < 4; i++) begin
      wr(3'h3, bad[i]);
      settle();
      check(pin_peripheral_owned & 8'h08, 8'h00, "unassigned owned");
      check(remappable_pin & 8'h08, 8'h00, "unassigned pin");
    end
  endtask : sc_unassigned

  task automatic sc_share();
    level_set = '0;
    level_set[SRC_REFCLK] = 1'b1;
    for (int p = 0; p < NUM_PINS; p++) begin
      wr(3'(p), SEL_REFCLK);
    end
    settle();
    check(pin_peripheral_owned, 8'hff, "shared owned");
    check(remappable_pin, 8'hff, "shared pins");
    level_set = '0;
    level_set[SRC_COMP4] = 1'b1;
    wr(3'h5, SEL_COMP4);
    settle();
    check(remappable_pin, 8'h20, "independent field");
  endtask : sc_share

  task automatic sc_reset();
    check(pin_peripheral_owned, 8'h00, "reset owned");
    check(remappable_pin, 8'h00, "reset pins");
    level_set = '1;
    settle();
    check(pin_peripheral_owned, 8'h00, "idle owned");
    check(remappable_pin, 8'h00, "idle pins");
  endtask : sc_reset

  // =============================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    wr_en = 1'b0;
    wr_pin = 3'h0;
    wr_code = 6'h00;
    level_set = '0;
    fail_count = 0;
    checks_done = 0;
    codes = '{SEL_UART_A_TX, SEL_UART_B_TX, SEL_SPI_B_DO, SEL_SPI_B_CK, SEL_SPI_B_SS, SEL_CAN_TX,
              SEL_CMP_OUT1, SEL_CMP_OUT2, SEL_CMP_OUT3, SEL_CMP_OUT4, SEL_COMP1, SEL_COMP2,
              SEL_COMP3, SEL_COMP4, SEL_PWM_SYNC, SEL_QEI_CMP, SEL_REFCLK};
    srcs = '{SRC_UART_A_TX, SRC_UART_B_TX, SRC_SPI_B_DO, SRC_SPI_B_CK, SRC_SPI_B_SS, SRC_CAN_TX,
             SRC_CMP_OUT1, SRC_CMP_OUT2, SRC_CMP_OUT3, SRC_CMP_OUT4, SRC_COMP1, SRC_COMP2,
             SRC_COMP3, SRC_COMP4, SRC_PWM_SYNC, SRC_QEI_CMP, SRC_REFCLK};
    repeat (6) @(posedge clock);
    #1;
    rstn = 1'b1;
    sc_reset();
    sc_codes();
    sc_unassigned();
    sc_share();
    // Mid-run reset must drop every mapping at once
    rstn = 1'b0;
    @(posedge clock);
    #1;
    rstn = 1'b1;
    sc_reset();
    end_of_test();
  end
endmodule : ropm_matrix_bench

// >>> tb/ropm_periph_model.sv
// Model of the peripheral output lines that feed the pin matrix
`timescale 1ns/1ps
module ropm_periph_model
  import ropm_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      rstn,
  input  wire ropm_src_t level_set,
  output ropm_src_t      lines
);
  // =============================================================
  // Peripheral levels
  // Launched off the clock edge, as registered peripheral outputs would be
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lines <= '0;
    end else begin
      lines <= level_set;
    end
  end
endmodule : ropm_periph_model
